// File: pcw_cfg_write.sv
// Behaviour
// R01 - a host write into configuration space issues a pci configuration write
// R02 - normal mode: ad 31:24 zero, ad 23:2 copied from host address
// R03 - ad 1:0 is 00 for type 0, 01 for type 1
// R04 - decoded mode only when host bits 23:22 are 11 and type 0
// R05 - decoded mode: host 15:11 gives one-hot ad 31:11, codes 2..20
// R06 - decoded mode: ad 10:2 copied, ad 1:0 zero
// R07 - byte enables come from host low address and access size
// R08 - exactly one dword per configuration write
// R09 - target retry: reissue the same write at first chance; code waits out a PCW_RETRY_BACKOFF countdown before requesting again
// R10 - master abort: drop data, set status bit 29, may interrupt
// R11 - target abort: drop data, set status bit 28, may interrupt
// R12 - software supplies a meaningful address, one device select bit
// R13 - no device select within five cycles after frame means master abort
// R14 - type 0 or type 1 chosen by which host window is hit
`timescale 1ns/100ps
module pcw_cfg_write
  import pcw_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst_b,
  input  wire logic        host_wr_req,
  input  wire logic [31:0] host_addr,
  input  wire logic [1:0]  host_addr_size_lines,
  input  wire logic [31:0] host_wdata,
  input  wire logic        irq_mabort_en,
  input  wire logic        irq_tabort_en,
  input  wire logic        status_clr,
  input  wire logic        pci_gnt_b,
  input  wire logic        pci_devsel_b,
  input  wire logic        pci_trdy_b,
  input  wire logic        pci_stop_b,
  output      logic        host_busy,
  output      logic        host_done,
  output      logic [31:0] pci_ad_out,
  output      logic        pci_ad_oe,
  output      logic [3:0]  pci_cbe_b_out,
  output      logic        pci_cbe_oe,
  output      logic        pci_frame_b_out,
  output      logic        pci_frame_oe,
  output      logic        pci_irdy_b_out,
  output      logic        pci_irdy_oe,
  output      logic        pci_req_b,
  output      logic        stat_mabort,
  output      logic        stat_tabort,
  output      logic        host_irq
);

  // --------------------------------------------------------------------------
  // pin capture
  // --------------------------------------------------------------------------
  logic [3:0] pins_s;

  pcw_sync #(.WIDTH(4)) u_sync (
    .clk   (clk),
    .rst_b (rst_b),
    .din   ({pci_gnt_b, pci_devsel_b, pci_trdy_b, pci_stop_b}),
    .dout  (pins_s)
  );

  logic gnt_s;
  logic devsel_s;
  logic trdy_s;
  logic stop_s;
  assign gnt_s    = ~pins_s[3];
  assign devsel_s = ~pins_s[2];
  assign trdy_s   = ~pins_s[1];
  assign stop_s   = ~pins_s[0];

  // --------------------------------------------------------------------------
  // grant qualification
  // --------------------------------------------------------------------------
  // the captured grant trails the pin by the capture depth, so a grant left
  // over from the previous owner is ignored until a fresh one can show
  logic [2:0] settle_reg;
  logic       gnt_ok;
  assign gnt_ok = gnt_s && settle_reg == 3'h0;

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      settle_reg <= 3'(PCW_GNT_SETTLE);
    else if (pci_req_b)
      settle_reg <= 3'(PCW_GNT_SETTLE);
    else if (settle_reg != 3'h0)
      settle_reg <= settle_reg - 3'h1;
  end

  // --------------------------------------------------------------------------
  // address forming
  // --------------------------------------------------------------------------
  function automatic logic [31:0] pcw_cfg_addr(input logic [31:0] a, input logic t1);
    logic [31:0] r;
    logic [4:0]  code;
    r    = '0;
    code = a[PCW_DEV_CODE_HI:PCW_DEV_CODE_LO];
    if (!t1 && a[PCW_DECODE_SEL_HI:PCW_DECODE_SEL_LO] == PCW_DECODE_SEL) // R04
    begin
      if (code >= PCW_DEV_CODE_FIRST && code <= PCW_DEV_CODE_LAST) // R05
        r[PCW_DEV_BIT_FIRST + int'(code - PCW_DEV_CODE_FIRST)] = 1'b1;
      r[10:2] = a[10:2]; // R06
      r[1:0]  = PCW_TYPE0_LOW; // R06
    end
    else
    begin
      r[31:24] = 8'h00; // R02
      r[23:2]  = a[23:2]; // R02
      r[1:0]   = t1 ? PCW_TYPE1_LOW : PCW_TYPE0_LOW; // R03
    end
    return r;
  endfunction

  // window decode picks the cycle type
  logic hit_t0;
  logic hit_t1;
  assign hit_t0 = host_addr[31:24] == PCW_WIN_TYPE0; // R14
  assign hit_t1 = host_addr[31:24] == PCW_WIN_TYPE1; // R14

  // --------------------------------------------------------------------------
  // latched request
  // --------------------------------------------------------------------------
  pcw_state_t  state_reg;
  logic [31:0] addr_reg;
  logic [31:0] data_reg;
  logic [3:0]  be_reg;
  logic [2:0]  wait_reg;
  logic [1:0]  backoff_reg;

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      addr_reg <= '0;
      data_reg <= '0;
      be_reg   <= 4'hf;
    end
    else if (state_reg == PCW_IDLE && !host_busy && host_wr_req && (hit_t0 || hit_t1)) // R01
    begin
      addr_reg <= pcw_cfg_addr(host_addr, hit_t1);
      data_reg <= host_wdata;
      be_reg   <= pcw_byte_en_b(host_addr[1:0], host_addr_size_lines); // R07
    end
  end

  // --------------------------------------------------------------------------
  // pci master sequence
  // --------------------------------------------------------------------------
  // a retry keeps the latched address and data so the reissue is identical
  logic ev_mabort;
  logic ev_tabort;
  logic ev_done;
  logic ev_retry;
  // a target that signals stop has answered, so that is never a master abort
  assign ev_mabort = state_reg == PCW_DATA && !devsel_s && !stop_s
                     && wait_reg == 3'(PCW_DEVSEL_WAIT);
  assign ev_tabort = state_reg == PCW_DATA && stop_s && !devsel_s && wait_reg != 3'h0
                     && !ev_mabort && pci_frame_b_out;
  assign ev_retry  = state_reg == PCW_DATA && stop_s && devsel_s && !trdy_s;
  assign ev_done   = state_reg == PCW_DATA && devsel_s && trdy_s;

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      state_reg   <= PCW_IDLE;
      wait_reg    <= 3'h0;
      backoff_reg <= 2'h0;
      host_busy   <= 1'b0;
      host_done   <= 1'b0;
      pci_req_b   <= 1'b1;
    end
    else
    begin
      host_done <= 1'b0;
      unique case (state_reg)
        PCW_IDLE:
        begin
          if (backoff_reg != 2'h0)
            backoff_reg <= backoff_reg - 2'h1;
          if (!host_busy && host_wr_req && (hit_t0 || hit_t1)) // R01
          begin
            host_busy <= 1'b1;
            pci_req_b <= 1'b0;
          end
          else if (host_busy && backoff_reg <= 2'h1)
            pci_req_b <= 1'b0;
          if (host_busy && gnt_ok && !pci_req_b) // R09
          begin
            state_reg <= PCW_ADDR;
            wait_reg  <= 3'h0;
          end
        end
        PCW_ADDR:
          state_reg <= PCW_DATA;
        PCW_DATA:
        begin
          wait_reg <= wait_reg + 3'h1;
          if (ev_retry) // R09
          begin
            state_reg   <= PCW_TURN;
            pci_req_b   <= 1'b1;
            backoff_reg <= PCW_RETRY_BACKOFF;
          end
          else if (ev_done || ev_mabort || ev_tabort) // R08 R10 R11
          begin
            state_reg <= PCW_TURN;
            pci_req_b <= 1'b1;
            host_busy <= 1'b0;
            host_done <= 1'b1;
          end
        end
        PCW_TURN:
          state_reg <= PCW_IDLE;
        default:
          state_reg <= PCW_IDLE;
      endcase
    end
  end

  // --------------------------------------------------------------------------
  // pin drive
  // --------------------------------------------------------------------------
  // single data phase: frame drops with the first irdy, so only one dword moves
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      pci_ad_out      <= '0;
      pci_ad_oe       <= 1'b0;
      pci_cbe_b_out   <= 4'hf;
      pci_cbe_oe      <= 1'b0;
      pci_frame_b_out <= 1'b1;
      pci_frame_oe    <= 1'b0;
      pci_irdy_b_out  <= 1'b1;
      pci_irdy_oe     <= 1'b0;
    end
    else
    begin
      unique case (state_reg)
        PCW_IDLE:
        begin
          if (host_busy && gnt_ok && !pci_req_b)
          begin
            pci_ad_out      <= addr_reg;
            pci_ad_oe       <= 1'b1;
            pci_cbe_b_out   <= PCW_CMD_CFG_WRITE;
            pci_cbe_oe      <= 1'b1;
            pci_frame_b_out <= 1'b0;
            pci_frame_oe    <= 1'b1;
            pci_irdy_oe     <= 1'b1;
          end
        end
        PCW_ADDR:
        begin
          pci_ad_out      <= data_reg;
          pci_cbe_b_out   <= be_reg; // R07
          pci_frame_b_out <= 1'b1; // R08
          pci_irdy_b_out  <= 1'b0;
        end
        PCW_DATA:
        begin
          if (ev_retry || ev_done || ev_mabort || ev_tabort) // R13
          begin
            pci_irdy_b_out <= 1'b1;
            pci_ad_oe      <= 1'b0;
            pci_cbe_oe     <= 1'b0;
          end
        end
        PCW_TURN:
        begin
          pci_frame_oe <= 1'b0;
          pci_irdy_oe  <= 1'b0;
        end
        default:
        begin
          pci_ad_oe <= 1'b0;
        end
      endcase
    end
  end

  // --------------------------------------------------------------------------
  // status and interrupt
  // --------------------------------------------------------------------------
  // set wins over a clear in the same cycle so no abort is lost
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      stat_mabort <= 1'b0;
      stat_tabort <= 1'b0;
      host_irq    <= 1'b0;
    end
    else
    begin
      if (ev_mabort) // R10 R13
        stat_mabort <= 1'b1;
      else if (status_clr)
        stat_mabort <= 1'b0;
      if (ev_tabort) // R11
        stat_tabort <= 1'b1;
      else if (status_clr)
        stat_tabort <= 1'b0;
      host_irq <= (stat_mabort && irq_mabort_en) || (stat_tabort && irq_tabort_en); // R10 R11
    end
  end

endmodule // pcw_cfg_write

// File: pcw_cfg_write_checker.sv
`timescale 1ns/100ps
module pcw_cfg_write_checker
  import pcw_pkg::*;
(
  input wire logic        clk,
  input wire logic        rst_b,
  input wire logic        host_wr_req,
  input wire logic [31:0] host_addr,
  input wire logic [31:0] host_wdata,
  input wire logic        status_clr,
  input wire logic        irq_mabort_en,
  input wire logic        irq_tabort_en,
  input wire logic        host_busy,
  input wire logic        host_done,
  input wire logic [31:0] pci_ad_out,
  input wire logic        pci_ad_oe,
  input wire logic [3:0]  pci_cbe_b_out,
  input wire logic        pci_frame_b_out,
  input wire logic        pci_frame_oe,
  input wire logic        pci_irdy_b_out,
  input wire logic        pci_irdy_oe,
  input wire logic        pci_req_b,
  input wire logic        stat_mabort,
  input wire logic        stat_tabort,
  input wire logic        host_irq
);
  // ----
  // request copy: a refused request may land here too, but starts no frame
  // ----
  logic [31:0] lat_a_reg;
  logic [31:0] lat_d_reg;
  wire         dec = lat_a_reg[23:22] == 2'h3 && !lat_a_reg[24];

  always_ff @(posedge clk or negedge rst_b)
    if (!rst_b)
      {lat_a_reg, lat_d_reg} <= 64'h0;
    else if (host_wr_req && !host_busy && !host_done)
      {lat_a_reg, lat_d_reg} <= {host_addr, host_wdata};

  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);

  sequence s_take;
    host_wr_req && !host_busy && !host_done && host_addr[31:25] == PCW_WIN_TYPE0[7:1];
  endsequence
  sequence s_addr;
    $fell(pci_frame_b_out) && pci_frame_oe;
  endsequence
  sequence s_data;
    pci_irdy_oe && !pci_irdy_b_out;
  endsequence

  a_take_request: assert property (s_take |=> host_busy && !pci_req_b)
    else $error("no request after take");
  a_addr_cmd: assert property (s_addr |-> pci_ad_oe && pci_cbe_b_out == PCW_CMD_CFG_WRITE)
    else $error("bad command");
  a_addr_type: assert property (s_addr |-> pci_ad_out[1:0] == {1'b0, lat_a_reg[24]})
    else $error("bad type bits");
  a_addr_normal: assert property ((s_addr and !dec) |->
    pci_ad_out[31:2] == {8'h00, lat_a_reg[23:2]})
    else $error("bad normal address");
  a_addr_decoded: assert property ((s_addr and dec) |-> pci_ad_out[10:2] == lat_a_reg[10:2]
    && $countones(pci_ad_out[31:11]) <= 1)
    else $error("bad decoded address");
  a_one_dword: assert property (s_addr |=> s_data ##0 pci_frame_b_out)
    else $error("not a single data phase");
  a_data_value: assert property (s_data and pci_ad_oe |-> pci_ad_out == lat_d_reg)
    else $error("bad write data");
  a_done_pulse: assert property (host_done |=> !host_done)
    else $error("done too long");
  a_mabort_sticky: assert property (stat_mabort && !status_clr |=> stat_mabort)
    else $error("master abort flag lost");
  a_tabort_sticky: assert property (stat_tabort && !status_clr |=> stat_tabort)
    else $error("target abort flag lost");
  a_irq_follow: assert property (host_irq == (
    $past(stat_mabort) && $past(irq_mabort_en) || $past(stat_tabort) && $past(irq_tabort_en)))
    else $error("bad interrupt");
endmodule // pcw_cfg_write_checker

// File: pcw_cfg_write_tb.sv
`timescale 1ns/100ps
module pcw_cfg_write_tb;
  import pcw_pkg::*;
  logic        clk, rst_b, host_wr_req, irq_mabort_en, irq_tabort_en, status_clr, slow;
  logic        pci_gnt_b, pci_devsel_b, pci_trdy_b, pci_stop_b, host_busy, host_done, pci_ad_oe;
  logic        pci_cbe_oe, pci_frame_b_out, pci_frame_oe, pci_irdy_b_out, pci_irdy_oe, pci_req_b;
  logic        stat_mabort, stat_tabort, host_irq;
  logic [1:0]  host_addr_size_lines, md;
  logic [31:0] host_addr, host_wdata, pci_ad_out, cap_ad, cap_d, a;
  logic [3:0]  pci_cbe_b_out, cap_cmd, cap_be;
  int          n_fail, checks_done, n_addr, cyc, w;

  pcw_cfg_write DUT (.clk, .rst_b, .host_wr_req, .host_addr, .host_addr_size_lines, .host_wdata,
    .irq_mabort_en, .irq_tabort_en, .status_clr, .pci_gnt_b, .pci_devsel_b, .pci_trdy_b,
    .pci_stop_b, .host_busy, .host_done, .pci_ad_out, .pci_ad_oe, .pci_cbe_b_out, .pci_cbe_oe,
    .pci_frame_b_out, .pci_frame_oe, .pci_irdy_b_out, .pci_irdy_oe, .pci_req_b, .stat_mabort,
    .stat_tabort, .host_irq);
  pcw_pci_target u_tgt (.clk, .rst_b, .md, .slow, .pci_req_b, .pci_irdy_b_out, .pci_irdy_oe,
    .pci_gnt_b, .pci_devsel_b, .pci_trdy_b, .pci_stop_b);

  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // ----
  // bus monitor and hang guard
  // ----
  always @(posedge clk)
  begin
    cyc++;
    if (pci_frame_oe && !pci_frame_b_out && pci_irdy_b_out)
    begin
      n_addr++;
      {cap_ad, cap_cmd} = {pci_ad_out, pci_cbe_oe ? pci_cbe_b_out : 4'h0};
    end
    if (pci_irdy_oe && !pci_irdy_b_out)
      {cap_d, cap_be} = (pci_ad_oe && pci_cbe_oe) ? {pci_ad_out, pci_cbe_b_out} : 36'hx;
    if (cyc == 20000)
    begin
      n_fail++;
      end_of_test;
    end
  end

  function automatic logic [31:0] ead(logic [31:0] x);
    int c;
    c = x[15:11];
    if (x[31:24] == PCW_WIN_TYPE1)
      return {8'h00, x[23:2], 2'h1};
    if (x[23:22] != 2'h3)
      return {8'h00, x[23:2], 2'h0};
    return ((c >= 2 && c <= 20) ? 32'h1 << (c + 11) : 32'h0) | {21'h0, x[10:2], 2'h0};
  endfunction

  function automatic logic [3:0] ebe(logic [1:0] x, logic [1:0] sz);
    if (sz == 2'h0)
      return ~(4'h1 << x);
    if (sz == 2'h1)
      return x[1] ? 4'h3 : 4'hc;
    return 4'h0;
  endfunction

  task automatic chk(logic [31:0] g, logic [31:0] e);
    checks_done++;
    if (g !== e)
    begin
      n_fail++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  task end_of_test;
    $display("checks=%0d fails=%0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // one write; the target's answer is picked by m
  task automatic do_wr(logic [31:0] ad, logic [31:0] d, logic [1:0] m);
    logic [1:0] sz;
    sz = 2'($urandom_range(3, 0));
    n_addr = 0;
    {host_wr_req, host_addr, host_addr_size_lines, host_wdata, md} <= {1'b1, ad, sz, d, m};
    {irq_mabort_en, irq_tabort_en, slow} <= 3'($urandom);
    @(posedge clk);
    host_wr_req <= 1'b0;
    w = 0;
    do @(negedge clk) w++; while (host_done !== 1'b1 && w < 400);
    chk(32'(host_done), 32'h1);
    repeat (2) @(negedge clk);
    chk(cap_ad, ead(ad));
    chk(32'(cap_cmd), 32'(PCW_CMD_CFG_WRITE));
    chk(32'(n_addr), 32'(1 + (m == 2'h1)));
    if (m < 2'h2) chk(cap_d, d);
    if (m < 2'h2) chk(32'(cap_be), 32'(ebe(ad[1:0], sz)));
    chk(32'(stat_mabort), 32'(m == 2'h3));
    chk(32'(stat_tabort), 32'(m == 2'h2));
    chk(32'(host_irq), 32'(m == 2'h3 && irq_mabort_en || m == 2'h2 && irq_tabort_en));
    @(posedge clk);
    status_clr <= 1'b1;
    @(posedge clk);
    status_clr <= 1'b0;
  endtask

  initial
  begin
    rst_b = 1'b0;
    {host_wr_req, irq_mabort_en, irq_tabort_en, status_clr, slow, md} = 7'h0;
    {host_addr, host_wdata, host_addr_size_lines} = 66'h0;
    void'($urandom(94257));
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    host_wr_req <= 1'b1;
    host_addr <= 32'h7e00_0000;
    repeat (3) @(posedge clk);
    host_wr_req <= 1'b0;
    @(negedge clk);
    chk(32'(host_busy), 32'h0);
    chk(32'(n_addr), 32'h0);
    @(posedge clk);
    for (int c = 0; c < 32; c++)
    begin
      a = $urandom;
      do_wr({8'h7c, 2'h3, a[21:16], c[4:0], a[10:0]}, $urandom, c[1:0]);
    end
    for (int i = 0; i < 16; i++)
    begin
      a = $urandom;
      a[31:23] = {i[0] ? 8'h7d : 8'h7c, i[0]};
      do_wr(a, $urandom, i[3:2]);
    end
    end_of_test;
  end
endmodule // pcw_cfg_write_tb

bind pcw_cfg_write pcw_cfg_write_checker u_chk (.clk, .rst_b, .host_wr_req, .host_addr,
  .host_wdata, .status_clr, .irq_mabort_en, .irq_tabort_en, .host_busy, .host_done,
  .pci_ad_out, .pci_ad_oe, .pci_cbe_b_out, .pci_frame_b_out, .pci_frame_oe, .pci_irdy_b_out,
  .pci_irdy_oe, .pci_req_b, .stat_mabort, .stat_tabort, .host_irq);

// File: pcw_pci_target.sv
`timescale 1ns/100ps
module pcw_pci_target
(
  input  wire logic       clk,
  input  wire logic       rst_b,
  input  wire logic [1:0] md,
  input  wire logic       slow,
  input  wire logic       pci_req_b,
  input  wire logic       pci_irdy_b_out,
  input  wire logic       pci_irdy_oe,
  output      logic       pci_gnt_b,
  output      logic       pci_devsel_b,
  output      logic       pci_trdy_b,
  output      logic       pci_stop_b
);
  // ----
  // md: 0 accept, 1 retry once then accept, 2 target abort, 3 no claim
  // ----
  logic [1:0] g_reg;
  logic [1:0] sel_reg;
  logic       irdy_q_reg;
  logic       retried_reg;
  wire        irdy_on = pci_irdy_oe && !pci_irdy_b_out;

  assign pci_gnt_b = slow ? g_reg[1] : g_reg[0];
  // lines released outside a data phase float high through the pull-ups
  assign {pci_devsel_b, pci_trdy_b, pci_stop_b} = !irdy_q_reg ? 3'h7 : sel_reg == 2'h0 ? 3'h1
    : sel_reg == 2'h1 ? 3'h2 : sel_reg == 2'h2 ? 3'h6 : 3'h7;

  always_ff @(posedge clk or negedge rst_b)
    if (!rst_b)
      g_reg <= 2'h3;
    else
      g_reg <= {g_reg[0], pci_req_b};

  // answer chosen once per data phase, held until the initiator lets go
  always_ff @(posedge clk or negedge rst_b)
    if (!rst_b)
      {irdy_q_reg, sel_reg, retried_reg} <= 4'h0;
    else
    begin
      irdy_q_reg <= irdy_on;
      if (irdy_on && !irdy_q_reg)
      begin
        sel_reg <= (md == 2'h1 && retried_reg) ? 2'h0 : md;
        retried_reg <= md == 2'h1 && !retried_reg;
      end
    end
endmodule // pcw_pci_target

// File: pcw_pkg.sv
package pcw_pkg;

  // --------------------------------------------------------------------------
  // pci command and address fields
  // --------------------------------------------------------------------------
  localparam logic [3:0] PCW_CMD_CFG_WRITE  = 4'hb;
  localparam logic [1:0] PCW_TYPE0_LOW      = 2'h0;
  localparam logic [1:0] PCW_TYPE1_LOW      = 2'h1;
  localparam logic [1:0] PCW_DECODE_SEL     = 2'h3;
  localparam int         PCW_DECODE_SEL_HI  = 23;
  localparam int         PCW_DECODE_SEL_LO  = 22;
  localparam int         PCW_DEV_CODE_HI    = 15;
  localparam int         PCW_DEV_CODE_LO    = 11;
  localparam logic [4:0] PCW_DEV_CODE_FIRST = 5'h02;
  localparam logic [4:0] PCW_DEV_CODE_LAST  = 5'h14;
  localparam int         PCW_DEV_BIT_FIRST  = 13;

  // --------------------------------------------------------------------------
  // host windows, status bits, timing
  // --------------------------------------------------------------------------
  localparam logic [7:0] PCW_WIN_TYPE0      = 8'h7c;
  localparam logic [7:0] PCW_WIN_TYPE1      = 8'h7d;
  localparam int         PCW_STAT_MABORT    = 29;
  localparam int         PCW_STAT_TABORT    = 28;
  localparam int         PCW_DEVSEL_WAIT    = 5;
  localparam logic [1:0] PCW_RETRY_BACKOFF  = 2'h2;
  localparam int         PCW_GNT_SETTLE     = 4;
  localparam int         PCW_CLK_MHZ        = 25;

  // --------------------------------------------------------------------------
  // types
  // --------------------------------------------------------------------------
  typedef enum logic [2:0] {
    PCW_IDLE,
    PCW_ADDR,
    PCW_DATA,
    PCW_TURN
  } pcw_state_t;

  // byte enables (active low) from low address and size: 0 byte, 1 half, 2 word
  function automatic logic [3:0] pcw_byte_en_b(input logic [1:0] a, input logic [1:0] sz);
    logic [3:0] en;
    en = 4'hf;
    unique case (sz)
      2'h0:    en = 4'h1 << a;
      2'h1:    en = a[1] ? 4'hc : 4'h3;
      default: en = 4'hf;
    endcase
    return ~en;
  endfunction

endpackage

// File: pcw_sync.sv
`timescale 1ns/100ps
module pcw_sync
  import pcw_pkg::*;
#(
  parameter int WIDTH = 4
)(
  input  wire logic             clk,
  input  wire logic             rst_b,
  input  wire logic [WIDTH-1:0] din,
  output      logic [WIDTH-1:0] dout
);

  // --------------------------------------------------------------------------
  // three stage capture; a change counts once stages two and three agree
  // --------------------------------------------------------------------------
  logic [WIDTH-1:0] s1_reg;
  logic [WIDTH-1:0] s2_reg;
  logic [WIDTH-1:0] s3_reg;

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      s1_reg <= '1;
      s2_reg <= '1;
      s3_reg <= '1;
      dout   <= '1;
    end
    else
    begin
      s1_reg <= din;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      for (int i = 0; i < WIDTH; i++)
      begin
        if (s2_reg[i] == s3_reg[i])
          dout[i] <= s3_reg[i];
      end
    end
  end

endmodule // pcw_sync
